// File: tdbw_defs.svh
// Offsets, field positions, reset values and widths of the burst window block
// Assumes inclusion by bare name from the package and the top module
`ifndef TDBW_DEFS_SVH
`define TDBW_DEFS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define TDBW_OFS_CTRL      8'h48
`define TDBW_OFS_WIN       8'h4c
`define TDBW_OFS_STATUS    8'h54

// ----------------------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------------------
`define TDBW_START_LSB     0
`define TDBW_LEN_LSB       8
`define TDBW_FIELD_W       5
`define TDBW_STAT_BUSY     8
`define TDBW_STAT_PEND     9

// ----------------------------------------------------------------------------
// Reset values and target map
// ----------------------------------------------------------------------------
`define TDBW_START_RST     5'h00
`define TDBW_LEN_RST       5'h00
`define TDBW_INDEX_RST     5'h00
`define TDBW_CTRL1_ADDR    8'h00
`define TDBW_ADDR_W        8
`define TDBW_DATA_W        16

`endif

// File: tdbw_pkg.sv
// Types shared by the burst window block
// Assumes tdbw_defs.svh is on the include path
package tdbw_pkg;
  `include "tdbw_defs.svh"

  typedef logic [`TDBW_ADDR_W-1:0]  tdbw_addr_t;
  typedef logic [`TDBW_DATA_W-1:0]  tdbw_data_t;
  typedef logic [`TDBW_FIELD_W-1:0] tdbw_field_t;

  typedef struct packed {
    logic       we;
    tdbw_addr_t addr;
    tdbw_data_t wdata;
    logic [1:0] be;
  } tdbw_req_s;

  typedef enum logic [1:0] {
    tdbw_st_idle,
    tdbw_st_rd_wait,
    tdbw_st_ack
  } tdbw_state_e;
endpackage

// File: tdbw_req_if.sv
// Valid/ready request channel between the window logic and its buffer
// Assumes both ends share clk_i
interface tdbw_req_if;
  import tdbw_pkg::*;
  logic      valid;
  logic      ready;
  tdbw_req_s req;

  modport src (output valid, output req, input ready);
  modport snk (input valid, input req, output ready);
endinterface

// File: tdbw_buf.sv
// Two-entry request buffer; head entry drives the output directly
// Assumes synchronous active-high reset on clk_i
module tdbw_buf (
  input  wire logic clk_i,
  input  wire logic rst_i,
  tdbw_req_if.snk   in_ch,
  tdbw_req_if.src   out_ch
);
  import tdbw_pkg::*;

  tdbw_req_s head;
  tdbw_req_s tail;
  logic      head_vld;
  logic      tail_vld;
  tdbw_req_s next_head;
  tdbw_req_s next_tail;
  logic      next_head_vld;
  logic      next_tail_vld;
  logic      pop;
  logic      push;

  assign in_ch.ready  = ~tail_vld;
  assign out_ch.valid = head_vld;
  assign out_ch.req   = head;

  always_comb begin
    pop           = head_vld & out_ch.ready;
    push          = in_ch.valid & ~tail_vld;
    next_head     = head;
    next_tail     = tail;
    next_head_vld = head_vld;
    next_tail_vld = tail_vld;
    if (pop) begin
      if (tail_vld) begin
        next_head     = tail;
        next_tail_vld = 1'b0;
      end else begin
        next_head_vld = 1'b0;
      end
    end
    if (push) begin
      if (!next_head_vld) begin
        next_head     = in_ch.req;
        next_head_vld = 1'b1;
      end else begin
        next_tail     = in_ch.req;
        next_tail_vld = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      head     <= '0;
      tail     <= '0;
      head_vld <= 1'b0;
      tail_vld <= 1'b0;
    end else begin
      head     <= next_head;
      tail     <= next_tail;
      head_vld <= next_head_vld;
      tail_vld <= next_tail_vld;
    end
  end
endmodule

// File: tdbw_top.sv
// Burst window of a timer: Wishbone slave plus redirected timer register port
// Assumes a classic Wishbone master and a timer register file on clk_i
//
// What this block does
// R1: Five-bit start offset in control bits 4:0
// R2: Five-bit length in bits 12:8, N+1 transfers
// R3: Window access targets control-one plus 4*(start+index)
// R4: Index advances per window access, bounded by length
// R5: Window accesses walk consecutive registers from start
// R6: Window accepts 16-bit and 8-bit items
// R7: 8-bit item carries register's most significant byte
// R8: Reserved control bits read zero, ignore writes
//
// Design decision made here: register access over Wishbone.
`include "tdbw_defs.svh"
module tdbw_top (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire tdbw_pkg::tdbw_addr_t wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic [31:0]             wb_dat_o,
  output logic                    wb_ack_o,
  output logic                    tgt_valid_o,
  input  wire logic               tgt_ready_i,
  output logic                    tgt_we_o,
  output tdbw_pkg::tdbw_addr_t    tgt_addr_o,
  output tdbw_pkg::tdbw_data_t    tgt_wdata_o,
  output logic [1:0]              tgt_be_o,
  input  wire logic               tgt_rvalid_i,
  input  wire tdbw_pkg::tdbw_data_t tgt_rdata_i
);
  import tdbw_pkg::*;

  // --------------------------------------------------------------------------
  // Helper functions
  // --------------------------------------------------------------------------
  function automatic tdbw_addr_t target_addr(input tdbw_field_t start,
                                             input tdbw_field_t index);
    logic [`TDBW_ADDR_W-1:0] sum;
    sum = {3'h0, start} + {3'h0, index};
    target_addr = `TDBW_CTRL1_ADDR + {sum[`TDBW_ADDR_W-3:0], 2'b00}; // [R3] [R5]
  endfunction

  function automatic logic is_byte_item(input logic [3:0] sel);
    is_byte_item = (sel[1:0] == 2'b01) || (sel[1:0] == 2'b10); // [R6]
  endfunction

  function automatic tdbw_field_t next_index(input tdbw_field_t index,
                                             input tdbw_field_t len);
    if (index >= len) begin
      next_index = `TDBW_INDEX_RST; // [R4]
    end else begin
      next_index = index + 5'h01; // [R4]
    end
  endfunction

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  tdbw_state_e state;
  tdbw_state_e next_state;
  tdbw_field_t start_ofs;
  tdbw_field_t next_start_ofs;
  tdbw_field_t xfer_len;
  tdbw_field_t next_xfer_len;
  tdbw_field_t xfer_index;
  tdbw_field_t next_xfer_index;
  logic        ack;
  logic        next_ack;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic        rd_byte;
  logic        next_rd_byte;
  logic [1:0]  rd_lane;
  logic [1:0]  next_rd_lane;

  logic        req_live;
  logic        hit_ctrl;
  logic        hit_win;
  logic        hit_stat;
  logic        byte_item;
  logic [7:0]  wr_byte;
  logic [31:0] rd_merge;

  tdbw_req_if push_ch ();
  tdbw_req_if pop_ch ();

  // --------------------------------------------------------------------------
  // Request buffer toward the timer registers
  // --------------------------------------------------------------------------
  tdbw_buf u_buf (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .in_ch  (push_ch),
    .out_ch (pop_ch)
  );

  assign pop_ch.ready = tgt_ready_i;
  assign tgt_valid_o  = pop_ch.valid;
  assign tgt_we_o     = pop_ch.req.we;
  assign tgt_addr_o   = pop_ch.req.addr;
  assign tgt_wdata_o  = pop_ch.req.wdata;
  assign tgt_be_o     = pop_ch.req.be;
  assign wb_ack_o     = ack;
  assign wb_dat_o     = rdata;

  // --------------------------------------------------------------------------
  // Address decode and window request build
  // --------------------------------------------------------------------------
  always_comb begin
    req_live  = wb_cyc_i & wb_stb_i & ~ack & (state == tdbw_st_idle);
    hit_ctrl  = (wb_adr_i[7:2] == 6'(`TDBW_OFS_CTRL >> 2));
    hit_win   = (wb_adr_i[7:2] == 6'(`TDBW_OFS_WIN >> 2));
    hit_stat  = (wb_adr_i[7:2] == 6'(`TDBW_OFS_STATUS >> 2));
    byte_item = is_byte_item(wb_sel_i);
    wr_byte   = wb_sel_i[0] ? wb_dat_i[7:0] : wb_dat_i[15:8];
    push_ch.valid     = req_live & hit_win; // [R5]
    push_ch.req.we    = wb_we_i;
    push_ch.req.addr  = target_addr(start_ofs, xfer_index); // [R3]
    if (byte_item) begin
      push_ch.req.wdata = {wr_byte, 8'h00}; // [R7]
      push_ch.req.be    = 2'b10; // [R7]
    end else begin
      push_ch.req.wdata = wb_dat_i[15:0]; // [R6]
      push_ch.req.be    = 2'b11; // [R6]
    end
  end

  // --------------------------------------------------------------------------
  // Read data return lane placement
  // --------------------------------------------------------------------------
  always_comb begin
    rd_merge = 32'h0000_0000;
    if (rd_byte) begin
      if (rd_lane[0]) begin
        rd_merge[7:0] = tgt_rdata_i[15:8]; // [R7]
      end else begin
        rd_merge[15:8] = tgt_rdata_i[15:8]; // [R7]
      end
    end else begin
      rd_merge[15:0] = tgt_rdata_i; // [R6]
    end
  end

  // --------------------------------------------------------------------------
  // Bus control and register state next values
  // --------------------------------------------------------------------------
  always_comb begin
    next_state      = state;
    next_start_ofs  = start_ofs;
    next_xfer_len   = xfer_len;
    next_xfer_index = xfer_index;
    next_ack        = 1'b0;
    next_rdata      = rdata;
    next_rd_byte    = rd_byte;
    next_rd_lane    = rd_lane;
    unique case (state)
      tdbw_st_idle: begin
        if (req_live) begin
          if (hit_win) begin
            if (push_ch.ready) begin
              next_xfer_index = next_index(xfer_index, xfer_len); // [R4] [R5]
              next_rd_byte    = byte_item;
              next_rd_lane    = wb_sel_i[1:0];
              if (wb_we_i) begin
                next_ack   = 1'b1;
                next_state = tdbw_st_ack;
              end else begin
                next_state = tdbw_st_rd_wait;
              end
            end
          end else begin
            next_ack   = 1'b1;
            next_state = tdbw_st_ack;
            next_rdata = 32'h0000_0000;
            if (hit_ctrl) begin
              if (wb_we_i) begin
                if (wb_sel_i[0]) begin
                  next_start_ofs = wb_dat_i[`TDBW_START_LSB +: `TDBW_FIELD_W]; // [R1] [R8]
                end
                if (wb_sel_i[1]) begin
                  next_xfer_len = wb_dat_i[`TDBW_LEN_LSB +: `TDBW_FIELD_W]; // [R2] [R8]
                end
                next_xfer_index = `TDBW_INDEX_RST;
              end else begin
                next_rdata[`TDBW_START_LSB +: `TDBW_FIELD_W] = start_ofs; // [R1] [R8]
                next_rdata[`TDBW_LEN_LSB +: `TDBW_FIELD_W]   = xfer_len; // [R2] [R8]
              end
            end else if (hit_stat && !wb_we_i) begin
              next_rdata[`TDBW_FIELD_W-1:0]  = xfer_index;
              next_rdata[`TDBW_STAT_BUSY]    = (xfer_index != `TDBW_INDEX_RST);
              next_rdata[`TDBW_STAT_PEND]    = pop_ch.valid;
            end
          end
        end
      end
      tdbw_st_rd_wait: begin
        if (tgt_rvalid_i) begin
          next_rdata = rd_merge;
          next_ack   = 1'b1;
          next_state = tdbw_st_ack;
        end
      end
      tdbw_st_ack: begin
        next_state = tdbw_st_idle;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state      <= tdbw_st_idle;
      start_ofs  <= `TDBW_START_RST;
      xfer_len   <= `TDBW_LEN_RST;
      xfer_index <= `TDBW_INDEX_RST;
      ack        <= 1'b0;
      rdata      <= 32'h0000_0000;
      rd_byte    <= 1'b0;
      rd_lane    <= 2'h0;
    end else begin
      state      <= next_state;
      start_ofs  <= next_start_ofs;
      xfer_len   <= next_xfer_len;
      xfer_index <= next_xfer_index;
      ack        <= next_ack;
      rdata      <= next_rdata;
      rd_byte    <= next_rd_byte;
      rd_lane    <= next_rd_lane;
    end
  end
endmodule

// File: tdbw_assertions.sv
// Port checker of the burst window block
// Assumes a bind onto tdbw_top
module tdbw_assertions
  import tdbw_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire tdbw_addr_t  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        tgt_valid_o,
  input wire logic        tgt_ready_i,
  input wire logic        tgt_we_o,
  input wire tdbw_addr_t  tgt_addr_o,
  input wire tdbw_data_t  tgt_wdata_o,
  input wire logic [1:0]  tgt_be_o,
  input wire logic        tgt_rvalid_i,
  input wire tdbw_data_t  tgt_rdata_i
);
  // ----
  // Properties
  // ----
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic win;
  assign win = wb_cyc_i && wb_stb_i && wb_adr_i[7:2] == 6'h13;
  property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack too long");
  property p_hold;
    tgt_valid_o && !tgt_ready_i |=> tgt_valid_o && $stable({tgt_we_o, tgt_addr_o, tgt_wdata_o, tgt_be_o});
  endproperty
  a_hold: assert property (p_hold) else $error("target request changed");
  property p_align; tgt_valid_o |-> tgt_addr_o[1:0] == 2'b00; endproperty
  a_align: assert property (p_align) else $error("target address unaligned");
  property p_be; tgt_valid_o |-> tgt_be_o == 2'b11 || tgt_be_o == 2'b10; endproperty
  a_be: assert property (p_be) else $error("bad target lanes");
  property p_rd16;
    win && !wb_we_i && wb_sel_i[1:0] == 2'b11 && tgt_rvalid_i |=> wb_ack_o && wb_dat_o[15:0] == $past(tgt_rdata_i);
  endproperty
  a_rd16: assert property (p_rd16) else $error("window read data wrong");
  property p_rd8;
    win && !wb_we_i && wb_sel_i[1:0] == 2'b01 && tgt_rvalid_i |=> wb_dat_o == ({16'h0, $past(tgt_rdata_i)} >> 8);
  endproperty
  a_rd8: assert property (p_rd8) else $error("byte read wrong");
  property p_resv;
    wb_cyc_i && wb_stb_i && !wb_we_i && wb_adr_i[7:2] == 6'h12 && wb_ack_o |-> wb_dat_o[7:5] == 3'h0
      && wb_dat_o[15:13] == 3'h0;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bits set");
  property p_wfwd; win && wb_we_i && wb_ack_o |-> ##[0:3] tgt_valid_o; endproperty
  a_wfwd: assert property (p_wfwd) else $error("window write lost");
  c_be8: cover property (tgt_valid_o && tgt_be_o == 2'b10);
  c_stall: cover property ((tgt_valid_o && !tgt_ready_i) [*3]);
  c_rd: cover property (tgt_rvalid_i ##1 wb_ack_o);
endmodule

// File: tdbw_tgt_model.sv
// Timer register file model behind the window
// Assumes requests held until taken
module tdbw_tgt_model (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        stall_i,
  input wire logic        valid_i,
  input wire logic        we_i,
  input wire logic [7:0]  addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic [1:0]  be_i,
  output logic            ready_o,
  output logic            rvalid_o,
  output logic [15:0]     rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [64];
  logic [15:0] q [$];
  int seed = 32'h1357;
  int r;
  initial begin
    for (int i = 0; i < 64; i++) mem[i] = {8'(i), ~8'(i)};
    ready_o = 0;
    rvalid_o = 0;
    rdata_o = 0;
  end
  // ----
  // Take, store and answer in order
  // ----
  always @(posedge clk_i) begin
    r = $random(seed);
    if (valid_i && ready_o) begin
      if (we_i) begin
        mem[addr_i[7:2]][15:8] <= wdata_i[15:8];
        if (be_i[0]) mem[addr_i[7:2]][7:0] <= wdata_i[7:0];
      end else q.push_back(mem[addr_i[7:2]]);
    end
    rvalid_o <= 0;
    rdata_o <= ~rdata_o;
    if (q.size() > 0 && r[1]) begin
      rvalid_o <= 1;
      rdata_o <= q.pop_front();
    end
    ready_o <= !stall_i && r[0];
    if (rst_i) begin
      ready_o <= 0;
      rvalid_o <= 0;
      q.delete();
    end
  end
endmodule

// File: tb_top.sv
// Self-checking bench of the burst window block
// Assumes design, model and checker compiled first
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import tdbw_pkg::*;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, stall = 0;
  logic [7:0] wb_adr_i = 0;
  logic [3:0] wb_sel_i = 0;
  logic [31:0] wb_dat_i = 0, wb_dat_o, q;
  logic wb_ack_o, tgt_valid_o, tgt_ready_i, tgt_we_o, tgt_rvalid_i;
  tdbw_addr_t tgt_addr_o;
  tdbw_data_t tgt_wdata_o, tgt_rdata_i;
  logic [1:0] tgt_be_o;
  logic [15:0] mem [64];
  logic [3:0] sels [4] = '{4'hf, 4'h1, 4'h2, 4'h3};
  int bad_count = 0, num_checks = 0, seed = 32'h2699, st, ln, idx, r;
  tdbw_top dut_u (.*);
  tdbw_tgt_model tgt_u (.clk_i(clk_i), .rst_i(rst_i), .stall_i(stall), .valid_i(tgt_valid_o),
    .we_i(tgt_we_o), .addr_i(tgt_addr_o), .wdata_i(tgt_wdata_o), .be_i(tgt_be_o),
    .ready_o(tgt_ready_i), .rvalid_o(tgt_rvalid_i), .rdata_o(tgt_rdata_i));
  initial forever #2 clk_i = ~clk_i;
  // ----
  // Tasks
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d bad %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
  endtask
  task automatic win(input logic w, input logic [3:0] s);
    logic [31:0] d;
    logic [5:0] a;
    a = 6'(st + idx);
    d = $random(seed);
    wb(w, 8'h4c, s, d);
    if (w && s[1:0] == 2'b11) mem[a] = d[15:0];
    else if (w) mem[a][15:8] = s[0] ? d[7:0] : d[15:8];
    else if (s[1:0] == 2'b11) chk(q & 32'hffff, {16'h0, mem[a]});
    else chk(q, s[0] ? {24'h0, mem[a][15:8]} : {16'h0, mem[a][15:8], 8'h0});
    idx = idx >= ln ? 0 : idx + 1;
  endtask
  initial begin
    repeat (50000) @(posedge clk_i);
    bad_count++;
    complete_run();
  end
  initial begin
    for (int i = 0; i < 64; i++) mem[i] = {8'(i), ~8'(i)};
    repeat (10) @(posedge clk_i);
    rst_i <= 0;
    wb(0, 8'h48, 4'hf, 0);
    chk(q & 32'hffff, 0);
    wb(1, 8'h48, 4'hf, 32'hffff);
    wb(0, 8'h48, 4'hf, 0);
    chk(q & 32'hffff, 32'h1f1f);
    wb(0, 8'h60, 4'hf, 0);
    chk(q, 0);
    wb(0, 8'h54, 4'hf, 0);
    chk(q, 0);
    for (int k = 0; k < 24; k++) begin
      st = k == 0 ? 31 : $random(seed) & 31;
      ln = k < 2 ? 17 : ($random(seed) & 255) % 18;
      wb(1, 8'h48, 4'h3, 32'(ln * 256 + st));
      idx = 0;
      wb(0, 8'h48, 4'h3, 0);
      chk(q & 32'hffff, 32'(ln * 256 + st));
      fork
        begin
          stall <= k[0];
          repeat (25) @(posedge clk_i);
          stall <= 0;
        end
        for (int j = 0; j < ln + 3; j++) begin
          r = $random(seed);
          win(r[0], sels[r[2:1]]);
        end
      join
      wb(0, 8'h54, 4'hf, 0);
      chk(q & 32'h011f, 32'(idx) | (idx != 0 ? 32'h100 : 32'h0));
    end
    complete_run();
  end
endmodule
bind tdbw_top tdbw_assertions chk_u (.*);
